// *** core/mac_unit.sv ***
// Multiply-accumulate datapath with APB configuration and result readback.
// Assumes operands and controls are synchronous to pclk; the four clock
// sources appear as enables on pclk.
//
// Register access over APB and the register offsets were left to the implementer.
`default_nettype none
module mac_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mac_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clock_enable_first,
	input wire logic clock_enable_second,
	input wire logic clock_enable_third,
	input wire logic clock_enable_fourth,
	input wire logic async_clear_first,
	input wire logic async_clear_second,
	input wire logic async_clear_third,
	input wire logic async_clear_fourth,
	input wire logic [mac_pkg::A_W-1:0] operand_a,
	input wire logic [mac_pkg::B_W-1:0] operand_b,
	input wire logic sign_a,
	input wire logic sign_b,
	input wire logic add_sub,
	input wire logic sync_load,
	input wire logic [mac_pkg::UP_W-1:0] sync_load_upper,
	output logic [mac_pkg::R_W-1:0] result,
	output logic overflow
);
	// ==========================================================
	// Declarations
	logic [mac_pkg::CFG_W-1:0] cfg_ff;
	logic [31:0] prdata_ff;
	logic [3:0] ce_vec;
	logic [3:0] clr_vec;
	logic [1:0] sl_clk, sl_clr, pl_clk, pl_clr, mr_clk, mr_clr, ac_clk, ac_clr;
	logic sl_reg_en, pl_en, mr_en, ovf_en;
	logic [3:0] lat_code;
	logic [mac_pkg::TAP_W-1:0] lat_tap;
	logic sl_ce, pl_ce, mr_ce, ac_ce;
	logic sl_clr_act, pl_clr_act, mr_clr_act, ac_clr_act;
	logic sl_rst_n, pl_rst_n, mr_rst_n, ac_rst_n;
	logic sl_in_ff, sl_pipe_ff, sl_stage, sl_eff;
	logic signed [mac_pkg::A_W:0] ext_a;
	logic signed [mac_pkg::B_W:0] ext_b;
	logic signed [mac_pkg::P_W-1:0] prod;
	logic [mac_pkg::P_W-1:0] mr_ff, mr_out, dly_out;
	logic [mac_pkg::R_W-1:0] prod_ext, feedback, result_ff, nxt_result;
	logic [mac_pkg::R_W:0] sum_wide;
	logic nxt_ovf, ovf_ff;
	logic acc_fire, apb_wr, apb_rd_setup, hit_cfg, hit_lo, hit_hi, addr_hit;
	logic [31:0] rd_mux;

	// ==========================================================
	// Configuration field decode
	assign sl_reg_en = cfg_ff[mac_pkg::CFG_SL_REG];
	assign sl_clk = cfg_ff[mac_pkg::CFG_SL_CLK +: 2];
	assign sl_clr = cfg_ff[mac_pkg::CFG_SL_CLR +: 2];
	assign pl_en = cfg_ff[mac_pkg::CFG_PL_EN];
	assign pl_clk = cfg_ff[mac_pkg::CFG_PL_CLK +: 2];
	assign pl_clr = cfg_ff[mac_pkg::CFG_PL_CLR +: 2];
	assign mr_en = cfg_ff[mac_pkg::CFG_MR_EN];
	assign mr_clk = cfg_ff[mac_pkg::CFG_MR_CLK +: 2];
	assign mr_clr = cfg_ff[mac_pkg::CFG_MR_CLR +: 2];
	assign lat_code = cfg_ff[mac_pkg::CFG_LAT +: 4];
	assign ac_clk = cfg_ff[mac_pkg::CFG_AC_CLK +: 2];
	assign ac_clr = cfg_ff[mac_pkg::CFG_AC_CLR +: 2];
	assign ovf_en = cfg_ff[mac_pkg::CFG_OVF_EN];

	// ==========================================================
	// Clock-enable and clear selection per stage
	assign ce_vec = {clock_enable_fourth, clock_enable_third,
		clock_enable_second, clock_enable_first};
	assign clr_vec = {async_clear_fourth, async_clear_third,
		async_clear_second, async_clear_first};
	assign sl_ce = ce_vec[sl_clk];
	assign pl_ce = ce_vec[pl_clk];
	assign mr_ce = ce_vec[mr_clk];
	assign ac_ce = ce_vec[ac_clk];
	// Code 3 means no clear on the load, pipeline and multiplier stages; on the accumulator it selects the fourth clear
	assign sl_clr_act = (sl_clr != mac_pkg::CLR_NONE) && clr_vec[sl_clr];
	assign pl_clr_act = (pl_clr != mac_pkg::CLR_NONE) && clr_vec[pl_clr];
	assign mr_clr_act = (mr_clr != mac_pkg::CLR_NONE) && clr_vec[mr_clr];
	assign ac_clr_act = clr_vec[ac_clr];
	// Clears act without the clock, merged with the bus reset
	assign sl_rst_n = presetn & ~sl_clr_act;
	assign pl_rst_n = presetn & ~pl_clr_act;
	assign mr_rst_n = presetn & ~mr_clr_act;
	assign ac_rst_n = presetn & ~ac_clr_act;

	// ==========================================================
	// Load control path: optional input register then pipeline register
	always_ff @(posedge pclk or negedge sl_rst_n) begin
		if (!sl_rst_n) begin
			sl_in_ff <= 1'b0;
		end else if (sl_ce) begin
			sl_in_ff <= sync_load;
		end
	end

	// Extra stage on the load path
	always_ff @(posedge pclk or negedge pl_rst_n) begin
		if (!pl_rst_n) begin
			sl_pipe_ff <= 1'b0;
		end else if (pl_ce) begin
			sl_pipe_ff <= sl_stage;
		end
	end

	// Bypass muxes for unregistered options
	assign sl_stage = sl_reg_en ? sl_in_ff : sync_load;
	assign sl_eff = pl_en ? sl_pipe_ff : sl_stage;

	// ==========================================================
	// Multiplier with per-operand signedness
	assign ext_a = {sign_a & operand_a[mac_pkg::A_W-1], operand_a};
	assign ext_b = {sign_b & operand_b[mac_pkg::B_W-1], operand_b};
	assign prod = ext_a * ext_b;

	// Optional register after the multiplier
	always_ff @(posedge pclk or negedge mr_rst_n) begin
		if (!mr_rst_n) begin
			mr_ff <= '0;
		end else if (mr_ce) begin
			mr_ff <= prod;
		end
	end
	assign mr_out = mr_en ? mr_ff : prod;

	// Codes 0..8 give that many cycles; any higher code gives 12
	assign lat_tap = (lat_code <= mac_pkg::LAT_CODE_LAST) ? lat_code :
		mac_pkg::LAT_TAP_LONG;

	// Latency stages share the multiplier register's enable and clear
	mac_dly u_dly (
		.pclk(pclk),
		.rst_n(mr_rst_n),
		.shift_en(mr_ce),
		.din(mr_out),
		.tap(lat_tap),
		.dout(dly_out)
	);

	// ==========================================================
	// Accumulator adder
	assign prod_ext = {{(mac_pkg::R_W-mac_pkg::P_W){dly_out[mac_pkg::P_W-1]}},
		dly_out};
	// Load replaces the stored value with upper data and zeros
	assign feedback = sl_eff ?
		{sync_load_upper, {(mac_pkg::R_W-mac_pkg::UP_W){1'b0}}} :
		result_ff;
	// Add when high, subtract when low, one bit wider for overflow
	assign sum_wide = add_sub ?
		{feedback[mac_pkg::R_W-1], feedback} +
		{prod_ext[mac_pkg::R_W-1], prod_ext} :
		{feedback[mac_pkg::R_W-1], feedback} -
		{prod_ext[mac_pkg::R_W-1], prod_ext};
	assign nxt_result = sum_wide[mac_pkg::R_W-1:0];
	assign nxt_ovf = sum_wide[mac_pkg::R_W] ^ sum_wide[mac_pkg::R_W-1];
	assign acc_fire = ac_ce;

	// Accumulator and overflow registers
	always_ff @(posedge pclk or negedge ac_rst_n) begin
		if (!ac_rst_n) begin
			result_ff <= '0;
			ovf_ff <= 1'b0;
		end else if (acc_fire) begin
			result_ff <= nxt_result;
			ovf_ff <= nxt_ovf;
		end
	end
	assign result = result_ff;
	assign overflow = ovf_ff & ovf_en;

	// ==========================================================
	// APB slave: zero wait states, error on unmapped offsets
	assign hit_cfg = (paddr == mac_pkg::OFF_CFG);
	assign hit_lo = (paddr == mac_pkg::OFF_RES_LO);
	assign hit_hi = (paddr == mac_pkg::OFF_RES_HI);
	assign addr_hit = hit_cfg | hit_lo | hit_hi;
	assign apb_wr = psel & penable & pwrite & hit_cfg;
	assign apb_rd_setup = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
	assign rd_mux = hit_cfg ? {{(32-mac_pkg::CFG_W){1'b0}}, cfg_ff} :
		hit_lo ? result_ff[31:0] :
		hit_hi ? {ovf_ff, {(63-mac_pkg::R_W){1'b0}},
		result_ff[mac_pkg::R_W-1:32]} :
		32'h00000000;

	// Configuration register and registered read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_ff <= mac_pkg::CFG_RST;
			prdata_ff <= 32'h00000000;
		end else begin
			if (apb_wr) begin
				cfg_ff <= pwdata[mac_pkg::CFG_W-1:0];
			end
			if (apb_rd_setup) begin
				prdata_ff <= rd_mux;
			end
		end
	end
	assign prdata = prdata_ff;

	// ==========================================================
	// Assertions

	// Load seeds the accumulator from the product and upper data
	AST_LOAD_ADD: assert property (@(posedge pclk)
		disable iff (!presetn)
		(sl_eff && add_sub && ac_ce && !ac_clr_act && sync_load_upper == '0)
		|=> ac_clr_act || result_ff == $past(prod_ext))
		else $error("load while adding did not take the product");
	AST_LOAD_SUB: assert property (@(posedge pclk)
		disable iff (!presetn)
		(sl_eff && !add_sub && ac_ce && !ac_clr_act && sync_load_upper == '0)
		|=> ac_clr_act || result_ff == ('0 - $past(prod_ext)))
		else $error("load while subtracting did not take minus product");
	AST_FEEDBACK: assert property (@(posedge pclk)
		disable iff (!presetn)
		(sl_eff && add_sub && ac_ce && !ac_clr_act)
		|=> ac_clr_act || result_ff ==
		{$past(sync_load_upper), {(mac_pkg::R_W-mac_pkg::UP_W){1'b0}}} +
		$past(prod_ext))
		else $error("load did not restart from the upper data");

	// Accumulation without load, and its enable and clear
	AST_ACC_ADD: assert property (@(posedge pclk)
		disable iff (!presetn)
		(!sl_eff && add_sub && ac_ce && !ac_clr_act)
		|=> ac_clr_act ||
		result_ff == $past(result_ff) + $past(prod_ext))
		else $error("accumulate add wrong");
	AST_ACC_SUB: assert property (@(posedge pclk)
		disable iff (!presetn)
		(!sl_eff && !add_sub && ac_ce && !ac_clr_act)
		|=> ac_clr_act ||
		result_ff == $past(result_ff) - $past(prod_ext))
		else $error("accumulate subtract wrong");
	AST_CLEAR: assert property (@(posedge pclk)
		disable iff (!presetn)
		ac_clr_act |-> result == '0 && !overflow)
		else $error("accumulator not held clear");
	AST_HOLD: assert property (@(posedge pclk)
		disable iff (!presetn)
		(!ac_ce && !ac_clr_act) |=> ac_clr_act || $stable(result_ff))
		else $error("accumulator changed without its enable");

	// Load control registers move only on their own enabled edge
	AST_SL_REG: assert property (@(posedge pclk)
		disable iff (!presetn)
		(sl_ce && !sl_clr_act)
		|=> sl_clr_act || sl_in_ff == $past(sync_load))
		else $error("load input register missed its edge");
	AST_SL_HOLD: assert property (@(posedge pclk)
		disable iff (!presetn)
		(!sl_ce && !sl_clr_act) |=> sl_clr_act || $stable(sl_in_ff))
		else $error("load input register changed without its enable");
	AST_PIPE: assert property (@(posedge pclk)
		disable iff (!presetn)
		(pl_en && pl_ce && !pl_clr_act)
		|=> pl_clr_act || !pl_en || sl_eff == $past(sl_stage))
		else $error("load pipeline register missed its edge");

	// Multiplier latency, overflow and signedness
	AST_LAT_ONE: assert property (@(posedge pclk)
		disable iff (!presetn)
		(lat_tap == 4'h1 && mr_ce && !mr_clr_act && $stable(lat_tap))
		|=> mr_clr_act || lat_tap != 4'h1 ||
		dly_out == $past(mr_out))
		else $error("one-cycle multiplier latency wrong");
	AST_OVF: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ovf_en && ac_ce && !ac_clr_act && $past(ovf_en))
		|=> ac_clr_act || !ovf_en ||
		overflow == ($past(sum_wide[mac_pkg::R_W]) !=
		$past(sum_wide[mac_pkg::R_W-1])))
		else $error("overflow flag wrong");
	AST_UNSIGNED: assert property (@(posedge pclk)
		disable iff (!presetn)
		(!sign_a && !sign_b) |-> !prod[mac_pkg::P_W-1])
		else $error("unsigned product came out negative");
endmodule : mac_unit
`default_nettype wire

// *** core/mac_pkg.sv ***
// Constants shared by the multiply-accumulate unit and its delay line.
// Assumes a single 250 MHz clock and an APB slave port for configuration.
`default_nettype none
package mac_pkg;
	// ==========================================================
	// Datapath widths
	localparam int A_W = 18;
	localparam int B_W = 18;
	localparam int P_W = 38;
	localparam int R_W = 52;
	localparam int UP_W = 8;
	localparam int DLY_DEPTH = 12;
	localparam int TAP_W = 4;
	localparam int SEL_W = 2;
	localparam int ADDR_W = 12;
	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFF_CFG = 12'h000;
	localparam logic [11:0] OFF_RES_LO = 12'h004;
	localparam logic [11:0] OFF_RES_HI = 12'h008;
	// ==========================================================
	// Configuration field positions
	localparam int CFG_SL_REG = 0;
	localparam int CFG_SL_CLK = 1;
	localparam int CFG_SL_CLR = 3;
	localparam int CFG_PL_EN = 5;
	localparam int CFG_PL_CLK = 6;
	localparam int CFG_PL_CLR = 8;
	localparam int CFG_MR_EN = 10;
	localparam int CFG_MR_CLK = 11;
	localparam int CFG_MR_CLR = 13;
	localparam int CFG_LAT = 15;
	localparam int CFG_AC_CLK = 19;
	localparam int CFG_AC_CLR = 21;
	localparam int CFG_OVF_EN = 23;
	localparam int CFG_W = 24;
	localparam int RES_HI_OVF = 31;
	// ==========================================================
	// Reset values and codes
	localparam logic [23:0] CFG_RST = 24'hE06318;
	localparam logic [1:0] CLR_NONE = 2'h3;
	localparam logic [3:0] LAT_CODE_LAST = 4'h8;
	localparam logic [3:0] LAT_TAP_LONG = 4'hC;
endpackage : mac_pkg
`default_nettype wire

// *** core/mac_dly.sv ***
// Delay line giving the multiplier product 0..12 extra cycles.
// Assumes the caller supplies the stage enable and combined reset.
`default_nettype none
module mac_dly (
	input wire logic pclk,
	input wire logic rst_n,
	input wire logic shift_en,
	input wire logic [mac_pkg::P_W-1:0] din,
	input wire logic [mac_pkg::TAP_W-1:0] tap,
	output logic [mac_pkg::P_W-1:0] dout
);
	// ==========================================================
	// Stage storage
	logic [mac_pkg::P_W-1:0] stage_ff [mac_pkg::DLY_DEPTH];
	logic [mac_pkg::TAP_W-1:0] tap_idx;

	// One flip-flop rank per extra cycle of latency
	genvar gi;
	generate
		for (gi = 0; gi < mac_pkg::DLY_DEPTH; gi++) begin : g_stage
			logic [mac_pkg::P_W-1:0] stage_in;
			if (gi == 0) begin : g_first
				assign stage_in = din;
			end else begin : g_next
				assign stage_in = stage_ff[gi-1];
			end
			always_ff @(posedge pclk or negedge rst_n) begin
				if (!rst_n) begin
					stage_ff[gi] <= '0;
				end else if (shift_en) begin
					stage_ff[gi] <= stage_in;
				end
			end
		end
	endgenerate

	// Tap select; tap zero bypasses the line
	assign tap_idx = tap - 4'h1;
	assign dout = (tap == '0) ? din : stage_ff[tap_idx];
endmodule : mac_dly
`default_nettype wire

// *** sim/mac_fabric.sv ***
// Fabric-side model driving multiplier operands and accumulator controls.
// Assumes the bench calls put() to launch one set at a rising pclk edge.
`default_nettype none
module mac_fabric (
	input wire logic pclk,
	output logic [mac_pkg::A_W-1:0] operand_a,
	output logic [mac_pkg::B_W-1:0] operand_b,
	output logic sign_a,
	output logic sign_b,
	output logic add_sub,
	output logic sync_load,
	output logic [mac_pkg::UP_W-1:0] sync_load_upper
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// Idle values at time zero
	initial begin
		{operand_a, operand_b} = '0;
		{sign_a, sign_b, add_sub, sync_load} = 4'h0;
		sync_load_upper = '0;
	end
	// Launch one operand set; c is {sign_a, sign_b, add_sub, sync_load}
	task put(input logic [17:0] a, b, input logic [3:0] c,
		input logic [7:0] u);
		@(posedge pclk);
		operand_a <= a;
		operand_b <= b;
		{sign_a, sign_b, add_sub, sync_load} <= c;
		sync_load_upper <= u;
	endtask : put
endmodule : mac_fabric
`default_nettype wire

// *** sim/mac_unit_tb_top.sv ***
// Self-checking bench for the multiply-accumulate unit.
// Assumes the fabric model in mac_fabric.sv and the core package.
`default_nettype none
module mac_unit_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, ovf, sa, sb, asb, sl;
	logic [3:0] ce = 4'h1;
	logic [3:0] clr = 4'h0;
	logic [17:0] opa, opb;
	logic [7:0] up;
	logic [51:0] res;
	logic [31:0] cfg0;
	int err_count = 0;
	int total_checks = 0;
	// ==========================================================
	// Clock, fabric model and design
	always #2 pclk = ~pclk;
	assign cfg0 = {8'h00, mac_pkg::CFG_RST};
	mac_fabric fab (.pclk(pclk), .operand_a(opa), .operand_b(opb),
		.sign_a(sa), .sign_b(sb), .add_sub(asb), .sync_load(sl),
		.sync_load_upper(up));
	mac_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clock_enable_first(ce[0]),
		.clock_enable_second(ce[1]), .clock_enable_third(ce[2]),
		.clock_enable_fourth(ce[3]), .async_clear_first(clr[0]),
		.async_clear_second(clr[1]), .async_clear_third(clr[2]),
		.async_clear_fourth(clr[3]), .operand_a(opa), .operand_b(opb),
		.sign_a(sa), .sign_b(sb), .add_sub(asb), .sync_load(sl),
		.sync_load_upper(up), .result(res), .overflow(ovf));
	// ==========================================================
	// Verdict, comparison and bus tasks
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	task chk(input logic [63:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer, waiting for pready under a bound
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin
			err_count++;
			complete_run();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb
	// ==========================================================
	// Scenarios
	task t_regs;
		apb(1'b0, mac_pkg::OFF_CFG, 32'h0);
		chk(rd, cfg0);
		apb(1'b1, 12'h00C, 32'hFFFFFFFF);
		chk(er, 1'b1);
		apb(1'b0, 12'h00C, 32'h0);
		chk({er, rd}, {1'b1, 32'h0});
		$display("register test done");
	endtask : t_regs
	task t_load;
		fab.put(18'h3, 18'h5, 4'h3, 8'h00);
		fab.put(18'h3, 18'h5, 4'h2, 8'h00);
		#1 chk(res, 52'hF);
		fab.put(18'h3, 18'h5, 4'h0, 8'h00);
		#1 chk({ovf, res}, 53'h1E);
		fab.put(18'h3, 18'h5, 4'h1, 8'h00);
		#1 chk(res, 52'hF);
		fab.put(18'h3, 18'h5, 4'h1, 8'h5A);
		#1 chk(res, 52'hFFFFFFFFFFFF1);
		fab.put(18'h3, 18'h5, 4'h2, 8'h00);
		#1 chk(res, 52'h59FFFFFFFFFF1);
		fab.put(18'h3FFFE, 18'h3, 4'hF, 8'h00);
		#1 chk(res, 52'h5A00000000000);
		fab.put(18'h3FFFE, 18'h3, 4'h7, 8'h00);
		#1 chk(res, 52'hFFFFFFFFFFFFA);
		fab.put(18'h3, 18'h5, 4'h3, 8'h00);
		#1 chk(res, 52'hBFFFA);
		$display("load test done");
	endtask : t_load
	task t_ena_clr;
		fab.put(18'h1, 18'h1, 4'h2, 8'h00);
		ce[0] <= 1'b0;
		repeat (3) @(posedge pclk);
		#1 chk(res, 52'hF);
		@(posedge pclk);
		ce[0] <= 1'b1;
		@(posedge pclk);
		#1 chk(res, 52'h10);
		@(posedge pclk);
		clr[3] <= 1'b1;
		#1 chk(res, 52'h0);
		@(posedge pclk);
		clr[3] <= 1'b0;
		clr[0] <= 1'b1;
		@(posedge pclk);
		#1 chk(res, 52'h1);
		@(posedge pclk);
		clr[0] <= 1'b0;
		$display("enable and clear test done");
	endtask : t_ena_clr
	task t_lat(input logic [3:0] code, input int n);
		apb(1'b1, mac_pkg::OFF_CFG, cfg0 | (32'(code) << mac_pkg::CFG_LAT));
		repeat (14) fab.put(18'h0, 18'h0, 4'h3, 8'h00);
		fab.put(18'h3, 18'h5, 4'h3, 8'h00);
		for (int k = 1; k <= n + 1; k++) begin
			fab.put(18'h0, 18'h0, 4'h3, 8'h00);
			#1 chk(res, (k == n + 1) ? 52'hF : 52'h0);
		end
		apb(1'b1, mac_pkg::OFF_CFG, cfg0);
		$display("latency test done");
	endtask : t_lat
	task t_sreg;
		apb(1'b1, mac_pkg::OFF_CFG, cfg0 | 32'h1);
		fab.put(18'h0, 18'h0, 4'h2, 8'h00);
		clr[3] <= 1'b1;
		@(posedge pclk);
		clr[3] <= 1'b0;
		fab.put(18'h3, 18'h5, 4'h3, 8'h00);
		fab.put(18'h3, 18'h5, 4'h2, 8'h00);
		#1 chk(res, 52'hF);
		fab.put(18'h3, 18'h5, 4'h2, 8'h00);
		#1 chk(res, 52'hF);
		fab.put(18'h3, 18'h5, 4'h2, 8'h00);
		#1 chk(res, 52'h1E);
		apb(1'b1, mac_pkg::OFF_CFG, cfg0 | 32'h21);
		fab.put(18'h3, 18'h5, 4'h3, 8'h00);
		repeat (3) fab.put(18'h3, 18'h5, 4'h2, 8'h00);
		#1 chk(res, 52'hF);
		fab.put(18'h3, 18'h5, 4'h2, 8'h00);
		#1 chk(res, 52'h1E);
		apb(1'b1, mac_pkg::OFF_CFG, cfg0);
		$display("load register test done");
	endtask : t_sreg
	task t_ovf;
		fab.put(18'h3FFFF, 18'h3, 4'h1, 8'h80);
		fab.put(18'h3FFFF, 18'h3, 4'h1, 8'h80);
		#1 chk({ovf, res}, {1'b1, 52'h7FFFFFFF40003});
		apb(1'b0, mac_pkg::OFF_RES_HI, 32'h0);
		chk({rd[31], rd[19:0]}, 21'h17FFFF);
		apb(1'b1, mac_pkg::OFF_CFG, cfg0 & ~(32'h1 << mac_pkg::CFG_OVF_EN));
		@(posedge pclk);
		#1 chk(ovf, 1'b0);
		apb(1'b1, mac_pkg::OFF_CFG, cfg0);
		$display("overflow test done");
	endtask : t_ovf
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_load();
		t_ena_clr();
		t_lat(4'h2, 2);
		t_lat(4'h1, 1);
		t_lat(4'h8, 8);
		t_lat(4'h9, 12);
		t_sreg();
		t_ovf();
		complete_run();
	end
endmodule : mac_unit_tb_top
`default_nettype wire
